// >>> logic/icp_parser.sv
// Purpose: command line syntax checker and serial poll status byte
// Assumes: one ASCII byte per rx_valid pulse; host logic drives the handshake
// Notes: command meaning is decoded downstream; here only syntax and status
module icp_parser (
	input wire logic mclk,
	input wire logic reset,
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	input wire logic [icp_pkg::NUM_FAULTS-1:0] fault_in,
	input wire logic [icp_pkg::NUM_FAULTS-1:0] source_enable,
	input wire logic power_on_request_switch,
	input wire logic serial_poll,
	input wire logic device_clear,
	input wire logic exec_busy,
	output logic [7:0] poll_status_byte,
	output logic service_request,
	output logic parallel_poll_bit,
	output logic [icp_pkg::NUM_FAULTS-1:0] fault_reg,
	output logic power_on_flag,
	output logic syntax_error,
	output logic cmd_valid,
	output logic [47:0] cmd_keyword,
	output logic cmd_last,
	output logic exec_start
);
	import icp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Character helpers
	function automatic logic [7:0] upcase(input logic [7:0] c);
		if (c >= 8'h61 && c <= 8'h7A) begin
			return c - 8'h20;
		end
		return c;
	endfunction : upcase

	function automatic logic is_digit(input logic [7:0] c);
		return c >= 8'h30 && c <= 8'h39;
	endfunction : is_digit

	function automatic logic is_alpha(input logic [7:0] c);
		return upcase(c) >= 8'h41 && upcase(c) <= 8'h5A;
	endfunction : is_alpha

	////////////////////////////////////////////////////////////////////////
	// Parser state
	icp_state_t state;
	icp_num_t nstate;
	logic [47:0] kw;
	logic [2:0] kw_len;
	logic [47:0] word;
	logic [2:0] word_len;
	logic [2:0] sig_count;
	logic point_seen;
	logic comma_seen;
	logic have_param;
	logic [7:0] suffix_first;
	logic [1:0] suffix_len;
	logic pulse_fault_q;
	logic pulse_err_q;
	logic pulse_clr;

	logic [7:0] ch;
	assign ch = upcase(rx_byte);

	// Parameter word legality: only full spellings of known mnemonics
	function automatic logic word_ok(input logic [47:0] w);
		case (w)
			48'h000000004356, 48'h000000004343, 48'h00000000_4F56,
			48'h000000004F54, 48'h000000005344, 48'h0000464F4C44,
			48'h000000455252, 48'h000000504F4E, 48'h00000052454D,
			48'h000000414346, 48'h0000004F5046, 48'h0000534E5350,
			48'h000000414C4C, 48'h00004E4F4E45, 48'h000000004F4E,
			48'h0000004F4646: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : word_ok

	// Unit suffix legality: none, A, mA, V, mV, S, mS
	function automatic logic suffix_ok(input logic [1:0] n, input logic [7:0] f,
			input logic [7:0] s);
		if (n == 2'd0) begin
			return 1'b1;
		end
		if (n == 2'd1) begin
			return f == 8'h41 || f == 8'h56 || f == 8'h53;
		end
		if (n == 2'd2) begin
			return f == 8'h4D && (s == 8'h41 || s == 8'h56 || s == 8'h53);
		end
		return 1'b0;
	endfunction : suffix_ok

	logic num_end_ok;
	assign num_end_ok = nstate == ICP_N_INT || nstate == ICP_N_FRAC
		|| nstate == ICP_N_EXP || nstate == ICP_N_SPACE;

	logic [7:0] suffix_second;
	logic param_ok;
	always_comb begin
		param_ok = 1'b1;
		if (state == ICP_WORD) begin
			param_ok = word_ok(word);
		end else if (state == ICP_NUM) begin
			param_ok = num_end_ok && sig_count <= 3'(MAX_SIG);
		end else if (state == ICP_SUFFIX) begin
			param_ok = num_end_ok && sig_count <= 3'(MAX_SIG)
				&& suffix_ok(suffix_len, suffix_first, suffix_second);
		end
	end

	logic is_sep;
	assign is_sep = ch == CH_SEMI || ch == CH_LF;

	////////////////////////////////////////////////////////////////////////
	// Character stream walk
	always_ff @(posedge mclk) begin
		pulse_fault_q <= 1'b0;
		pulse_err_q <= 1'b0;
		pulse_clr <= 1'b0;
		cmd_valid <= 1'b0;
		exec_start <= 1'b0;
		if (reset) begin
			state <= ICP_KEY;
			nstate <= ICP_N_SIGN;
			kw <= '0;
			kw_len <= '0;
			word <= '0;
			word_len <= '0;
			sig_count <= '0;
			point_seen <= 1'b0;
			comma_seen <= 1'b0;
			have_param <= 1'b0;
			suffix_first <= '0;
			suffix_second <= '0;
			suffix_len <= '0;
			cmd_keyword <= '0;
			cmd_last <= 1'b0;
		end else if (rx_valid) begin
			if (is_sep) begin
				// bad commands are dropped, good ones leave in order
				if (state != ICP_BAD && kw_len != 3'd0 && param_ok
						&& !(comma_seen && state == ICP_AFTER)) begin
					cmd_valid <= 1'b1;
					cmd_keyword <= kw;
					cmd_last <= ch == CH_LF;
					if (kw == KW_FAULT_Q) begin
						pulse_fault_q <= 1'b1;
					end
					if (kw == KW_ERR_Q) begin
						pulse_err_q <= 1'b1;
					end
					if (kw == KW_CLR && !have_param) begin
						pulse_clr <= 1'b1;
					end
				end
				if (ch == CH_LF) begin
					exec_start <= 1'b1;
				end
				state <= ICP_KEY;
				kw <= '0;
				kw_len <= '0;
				have_param <= 1'b0;
				comma_seen <= 1'b0;
			end else begin
				case (state)
					ICP_KEY: begin
						if (ch == CH_SP) begin
							if (kw_len != 3'd0) begin
								state <= ICP_GAP;
							end
						end else if ((is_alpha(ch) || ch == CH_QUERY)
								&& kw_len != 3'(KW_LEN)) begin
							kw <= {kw[39:0], ch};
							kw_len <= kw_len + 3'd1;
						end else begin
							state <= ICP_BAD;
						end
					end
					ICP_GAP, ICP_AFTER: begin
						if (ch == CH_SP) begin
							state <= state;
						end else if (ch == CH_COMMA) begin
							if (comma_seen || !have_param) begin
								state <= ICP_BAD;
							end else begin
								comma_seen <= 1'b1;
							end
						end else if (have_param && !comma_seen) begin
							state <= ICP_BAD;
						end else begin
							have_param <= 1'b1;
							comma_seen <= 1'b0;
							word <= {40'h0, ch};
							word_len <= 3'd1;
							sig_count <= is_digit(ch) ? 3'd1 : 3'd0;
							point_seen <= ch == CH_POINT;
							suffix_len <= '0;
							if (is_alpha(ch)) begin
								state <= ICP_WORD;
							end else if (is_digit(ch)) begin
								state <= ICP_NUM;
								nstate <= ICP_N_INT;
							end else if (ch == CH_POINT) begin
								state <= ICP_NUM;
								nstate <= ICP_N_FRAC;
							end else if (ch == CH_PLUS || ch == CH_MINUS) begin
								state <= ICP_NUM;
								nstate <= ICP_N_SIGN;
							end else begin
								state <= ICP_BAD;
							end
						end
					end
					ICP_WORD: begin
						if (ch == CH_SP || ch == CH_COMMA) begin
							if (!word_ok(word)) begin
								state <= ICP_BAD;
							end else begin
								state <= ICP_AFTER;
								comma_seen <= ch == CH_COMMA;
							end
						end else if (is_alpha(ch) && word_len != 3'(KW_LEN)) begin
							word <= {word[39:0], ch};
							word_len <= word_len + 3'd1;
						end else begin
							state <= ICP_BAD;
						end
					end
					ICP_NUM: begin
						if (is_digit(ch)) begin
							if (nstate == ICP_N_SPACE) begin
								state <= ICP_BAD;
							end else if (nstate == ICP_N_ESIGN || nstate == ICP_N_EXP) begin
								nstate <= ICP_N_EXP;
							end else begin
								if (nstate == ICP_N_SIGN) begin
									nstate <= ICP_N_INT;
								end
								if (sig_count != 3'd7) begin
									sig_count <= sig_count + 3'd1;
								end
							end
						end else if (ch == CH_POINT) begin
							if (point_seen || nstate == ICP_N_SPACE
									|| nstate == ICP_N_ESIGN || nstate == ICP_N_EXP) begin
								state <= ICP_BAD;
							end else begin
								point_seen <= 1'b1;
								nstate <= ICP_N_FRAC;
							end
						end else if (ch == 8'h45 && (nstate == ICP_N_INT
								|| nstate == ICP_N_FRAC)) begin
							nstate <= ICP_N_ESIGN;
						end else if ((ch == CH_PLUS || ch == CH_MINUS)
								&& nstate == ICP_N_ESIGN) begin
							nstate <= ICP_N_EXP;
						end else if (ch == CH_SP && num_end_ok) begin
							nstate <= ICP_N_SPACE;
						end else if (ch == CH_COMMA && num_end_ok
								&& sig_count <= 3'(MAX_SIG)) begin
							state <= ICP_AFTER;
							comma_seen <= 1'b1;
						end else if (is_alpha(ch) && num_end_ok
								&& nstate != ICP_N_SPACE) begin
							state <= ICP_SUFFIX;
							suffix_first <= ch;
							suffix_len <= 2'd1;
						end else begin
							state <= ICP_BAD;
						end
					end
					ICP_SUFFIX: begin
						if (ch == CH_SP || ch == CH_COMMA) begin
							if (!suffix_ok(suffix_len, suffix_first, suffix_second)) begin
								state <= ICP_BAD;
							end else begin
								state <= ICP_AFTER;
								comma_seen <= ch == CH_COMMA;
							end
						end else if (is_alpha(ch) && suffix_len == 2'd1) begin
							suffix_second <= ch;
							suffix_len <= 2'd2;
						end else begin
							state <= ICP_BAD;
						end
					end
					default: state <= ICP_BAD;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Fault register and status byte
	logic [NUM_FAULTS-1:0] next_fault;
	logic err_event;
	assign err_event = rx_valid && is_sep && (state == ICP_BAD
		|| (kw_len != 3'd0 && (!param_ok || (comma_seen && state == ICP_AFTER))));
	always_comb begin
		next_fault = fault_in;
		next_fault[FLT_ERR] = fault_in[FLT_ERR] | syntax_error;
	end

	logic fault_event;
	logic rqs_source;
	logic pon_pending;
	assign fault_event = |(next_fault & ~fault_reg);
	// Only the request path sees the enables; stored bits are untouched
	assign rqs_source = |(next_fault & ~fault_reg & source_enable);

	always_ff @(posedge mclk) begin
		if (reset) begin
			syntax_error <= 1'b0;
		end else if (err_event) begin
			syntax_error <= 1'b1;
		end else if (pulse_err_q) begin
			syntax_error <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			fault_reg <= '0;
			power_on_flag <= 1'b0;
			pon_pending <= 1'b1;
		end else begin
			fault_reg <= next_fault;
			pon_pending <= 1'b0;
			if (pon_pending) begin
				power_on_flag <= power_on_request_switch;
			end else if (pulse_clr || device_clear) begin
				power_on_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			poll_status_byte <= STATUS_RESET;
			service_request <= 1'b1;
			parallel_poll_bit <= 1'b1;
		end else begin
			if (fault_event) begin
				poll_status_byte[SB_FAULT] <= 1'b1;
			end else if (pulse_fault_q) begin
				poll_status_byte[SB_FAULT] <= 1'b0;
			end
			poll_status_byte[3:1] <= 3'b000;
			poll_status_byte[SB_READY] <= !exec_busy && !exec_start;
			if (err_event || (next_fault[FLT_ERR] && !fault_reg[FLT_ERR])) begin
				poll_status_byte[SB_ERROR] <= 1'b1;
			end else if (pulse_err_q) begin
				poll_status_byte[SB_ERROR] <= 1'b0;
			end
			// Set beats poll-clear so a fault in the poll cycle is kept
			if (rqs_source) begin
				service_request <= 1'b1;
				poll_status_byte[SB_RQS] <= 1'b1;
			end else if (serial_poll) begin
				service_request <= 1'b0;
				poll_status_byte[SB_RQS] <= 1'b0;
			end
			if (pulse_clr || device_clear) begin
				poll_status_byte[SB_PON] <= 1'b0;
				parallel_poll_bit <= 1'b0;
			end
		end
	end
endmodule : icp_parser

// >>> logic/icp_pkg.sv
// Purpose: constants for the command parser and serial poll status logic
// Assumes: ASCII bytes arrive one per strobe, synchronous to mclk
// Notes: status byte bit positions and fault vector layout live here
// What this block does
// - Assert service request after power-up and whenever a source-enabled fault occurs.
// - Exactly ten fault inputs: cv, cc, ov, ot, sd, fold, err, acf, opf, sense_protect_flag.
// - Record power-on in fault register only when the switch is on.
// - Source enables gate request generation only, never stored conditions or indicators.
// - Serial poll returns an eight-bit status byte.
// - Bit 0 set by any fault, cleared by fault query.
// - Bit 4 high when ready, low while commands are processed.
// - Bit 5 set by error status bit, cleared by error query.
// - Bit 6 set while requesting service, cleared by serial poll.
// - Bit 7 set at power-on, cleared by initialize command or device clear.
// - Keywords and mnemonic parameters accepted in any letter case.
// - Only full spellings accepted; shortened forms rejected.
// - Space separates keyword and parameter; space runs count as one.
// - Reject spaces inside a number between digits or digit and point.
// - Sender separates parameters with commas.
// - Exactly one comma between parameters, spaces allowed; two commas is an error.
// - Current default amps, mA milliamps; voltage default volts, mV millivolts.
// - Time default seconds; s seconds; ms milliseconds.
// - State parameter takes 1 or ON as true, 0 or OFF as false.
// - Numbers carry four significant figures with optional sign.
// - At most one decimal point in a number.
// - Exponent after E or e must be a signed or unsigned integer; a lone sign after E with no digits is also accepted.
// - Semicolons separate commands; spaces around them ignored.
// - Line feed ends a line and starts execution of buffered commands.
// - Commands execute strictly in order of arrival.
// - Parallel poll reflects bit 7 and does not clear the request.
package icp_pkg;
	localparam int NUM_FAULTS = 10;
	localparam int FLT_ERR = 6;
	localparam int SB_FAULT = 0;
	localparam int SB_READY = 4;
	localparam int SB_ERROR = 5;
	localparam int SB_RQS = 6;
	localparam int SB_PON = 7;
	localparam int KW_LEN = 6;
	localparam int MAX_SIG = 4;
	localparam logic [7:0] STATUS_RESET = 8'hC0;
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [7:0] CH_COMMA = 8'h2C;
	localparam logic [7:0] CH_SEMI = 8'h3B;
	localparam logic [7:0] CH_QUERY = 8'h3F;
	localparam logic [7:0] CH_PLUS = 8'h2B;
	localparam logic [7:0] CH_MINUS = 8'h2D;
	localparam logic [7:0] CH_POINT = 8'h2E;
	localparam logic [47:0] KW_FAULT_Q = 48'h4641554C543F;
	localparam logic [47:0] KW_ERR_Q = 48'h00004552523F;
	localparam logic [47:0] KW_CLR = 48'h000000434C52;
	typedef enum logic [2:0] {
		ICP_KEY, ICP_GAP, ICP_WORD, ICP_NUM, ICP_SUFFIX, ICP_AFTER, ICP_BAD
	} icp_state_t;
	typedef enum logic [2:0] {
		ICP_N_SIGN, ICP_N_INT, ICP_N_FRAC, ICP_N_ESIGN, ICP_N_EXP, ICP_N_SPACE
	} icp_num_t;
endpackage : icp_pkg

// >>> sim/icp_host_model.sv
// Purpose: bus controller sending command lines and polls
// Assumes: bytes change at the falling edge
// Notes: data idles at a changing pattern so stale bytes are never trusted
module icp_host_model (
	input wire logic mclk,
	output logic rx_valid,
	output logic [7:0] rx_byte,
	output logic serial_poll,
	output logic device_clear
);
	timeunit 1ns;
	timeprecision 1ps;
	import icp_pkg::*;
	initial begin
		rx_valid = 1'b0;
		rx_byte = 8'h5A;
		serial_poll = 1'b0;
		device_clear = 1'b0;
	end
////////////////////////////////////////
	task automatic send_line(input string s, input int gap);
		for (int i = 0; i <= s.len(); i++) begin
			@(negedge mclk);
			rx_valid = 1'b1;
			rx_byte = (i == s.len()) ? CH_LF : 8'(s[i]);
			repeat (gap) begin
				@(negedge mclk);
				rx_valid = 1'b0;
				rx_byte = ~rx_byte;
			end
		end
		@(negedge mclk);
		rx_valid = 1'b0;
		rx_byte = ~rx_byte;
	endtask : send_line
	task automatic pulse(input logic poll);
		@(negedge mclk);
		serial_poll = poll;
		device_clear = !poll;
		@(negedge mclk);
		serial_poll = 1'b0;
		device_clear = 1'b0;
	endtask : pulse
endmodule : icp_host_model

// >>> sim/icp_parser_assertions.sv
// Purpose: port-level timing checks for the command parser
// Assumes: one clock domain, reset synchronous active high
// Notes: windows allow one or two spare cycles where latency is a design choice
module icp_parser_assertions (
	input wire logic mclk,
	input wire logic reset,
	input wire logic rx_valid,
	input wire logic [7:0] rx_byte,
	input wire logic [icp_pkg::NUM_FAULTS-1:0] fault_in,
	input wire logic [icp_pkg::NUM_FAULTS-1:0] source_enable,
	input wire logic power_on_request_switch,
	input wire logic serial_poll,
	input wire logic device_clear,
	input wire logic exec_busy,
	input wire logic [7:0] poll_status_byte,
	input wire logic service_request,
	input wire logic parallel_poll_bit,
	input wire logic [icp_pkg::NUM_FAULTS-1:0] fault_reg,
	input wire logic power_on_flag,
	input wire logic syntax_error,
	input wire logic cmd_valid,
	input wire logic [47:0] cmd_keyword,
	input wire logic cmd_last,
	input wire logic exec_start
);
	import icp_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
////////////////////////////////////////
	a_unused_zero: assert property (poll_status_byte[3:1] == 3'h0)
		else $error("unused status bits not zero");
	a_ppoll_mirror: assert property (parallel_poll_bit == poll_status_byte[SB_PON])
		else $error("parallel poll bit differs from power-on bit");
	a_lf_exec: assert property (rx_valid && rx_byte == CH_LF |=> exec_start)
		else $error("line feed without execution start");
	a_exec_cause: assert property (exec_start |-> $past(rx_valid && rx_byte == CH_LF))
		else $error("execution start without line feed");
	a_cmd_cause: assert property (cmd_valid |-> $past(rx_valid) &&
		($past(rx_byte) == CH_SEMI || $past(rx_byte) == CH_LF))
		else $error("command without terminator");
	a_busy_not_ready: assert property (exec_busy [*2] |-> !poll_status_byte[SB_READY])
		else $error("ready bit high while busy");
	a_fault_bit_set: assert property ((|(fault_in & ~$past(fault_in) & 10'h3BF))
		|-> ##[1:2] poll_status_byte[SB_FAULT])
		else $error("fault bit not set");
	a_srq_on_fault: assert property ((|(fault_in & ~$past(fault_in) & source_enable & 10'h3BF))
		|-> ##[1:3] service_request)
		else $error("enabled fault gives no service request");
	a_rqs_mirror: assert property (poll_status_byte[SB_RQS] == service_request)
		else $error("request bit differs from service request");
	a_last_on_lf: assert property (cmd_valid |-> cmd_last == ($past(rx_byte) == CH_LF))
		else $error("command end flag wrong");
	a_err_bit_set: assert property ($rose(syntax_error) |-> ##[0:2] poll_status_byte[SB_ERROR])
		else $error("error bit not set");
	a_clear_drops_pon: assert property (device_clear |-> ##[1:2] !poll_status_byte[SB_PON])
		else $error("device clear left power-on bit");
	// Error input bit is also fed by the parser, so skip it
	a_fault_recorded: assert property ((($past(fault_in) & ~fault_reg) & 10'h3BF) == 10'h000)
		else $error("fault input not recorded");
	c_exec: cover property (exec_start);
	c_err_cleared: cover property ($fell(syntax_error));
	c_mid_line: cover property (cmd_valid && !cmd_last);
	c_poll: cover property (serial_poll ##1 !poll_status_byte[SB_RQS]);
endmodule : icp_parser_assertions

bind icp_parser icp_parser_assertions chk_u (.mclk, .reset, .rx_valid, .rx_byte, .fault_in,
	.source_enable, .power_on_request_switch, .serial_poll, .device_clear, .exec_busy,
	.poll_status_byte, .service_request, .parallel_poll_bit, .fault_reg, .power_on_flag,
	.syntax_error, .cmd_valid, .cmd_keyword, .cmd_last, .exec_start);

// >>> sim/instrument_command_parser_status_tb_top.sv
// Purpose: self-checking bench for the parser and poll status byte
// Assumes: inputs change at the falling edge
// Notes: line tables mix fixed corner cases with random case and spacing
module instrument_command_parser_status_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import icp_pkg::*;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic rx_valid;
	logic [7:0] rx_byte;
	logic [NUM_FAULTS-1:0] fault_in = '0;
	logic [NUM_FAULTS-1:0] source_enable = '0;
	logic power_on_request_switch = 1'b1;
	logic serial_poll;
	logic device_clear;
	logic exec_busy = 1'b0;
	logic [7:0] poll_status_byte;
	logic service_request;
	logic parallel_poll_bit;
	logic [NUM_FAULTS-1:0] fault_reg;
	logic power_on_flag;
	logic syntax_error;
	logic cmd_valid;
	logic [47:0] cmd_keyword;
	logic cmd_last;
	logic exec_start;
	logic [47:0] last_kw;
	int errors = 0;
	int samples_checked = 0;
	int cmd_count = 0;
	int seed = 32'h6603A8F9;
	int f;
	string good[7] = '{"vset 5mv", "iset 2.0a ; vset   +1.234e-1", "mask cv , ov,fold",
		"out on;out 0;out 1;out off", "dly 10ms", "dly 1.5s", "ovset -0.123e+1"};
	string bad[5] = '{"vout 3. 4", "mask cv,,ov", "vset 1.2.3", "vset 1e1.5", "vset 1.2345"};
	always #12.5 mclk = ~mclk;
	icp_parser dut_u (.mclk, .reset, .rx_valid, .rx_byte, .fault_in, .source_enable,
		.power_on_request_switch, .serial_poll, .device_clear, .exec_busy, .poll_status_byte,
		.service_request, .parallel_poll_bit, .fault_reg, .power_on_flag, .syntax_error,
		.cmd_valid, .cmd_keyword, .cmd_last, .exec_start);
	icp_host_model host_u (.mclk, .rx_valid, .rx_byte, .serial_poll, .device_clear);
	always @(posedge mclk) begin
		if (cmd_valid === 1'b1) begin
			cmd_count++;
			last_kw = cmd_keyword;
		end
	end
////////////////////////////////////////
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test
	function automatic int n_cmds(input string s);
		n_cmds = 1;
		for (int i = 0; i < s.len(); i++) begin
			if (s[i] == ";") n_cmds++;
		end
	endfunction : n_cmds
	function automatic string mangle(input string s);
		for (int i = 0; i < s.len(); i++) begin
			if (s[i] >= "a" && s[i] <= "z" && $random(seed) % 2 != 0) s[i] = s[i] - 8'h20;
		end
		return s;
	endfunction : mangle
	task automatic wait_n(input int n);
		repeat (n) @(negedge mclk);
	endtask : wait_n
	task automatic do_reset(input logic sw);
		@(negedge mclk);
		reset = 1'b1;
		power_on_request_switch = sw;
		wait_n(4);
		reset = 1'b0;
		wait_n(2);
	endtask : do_reset
	task automatic run(input string s, input logic err);
		cmd_count = 0;
		host_u.send_line(s, $unsigned($random(seed)) % 3);
		wait_n(3);
		check(syntax_error, err);
		if (!err) begin
			check(48'(cmd_count), 48'(n_cmds(s)));
		end else begin
			check(poll_status_byte[SB_ERROR], 1'b1);
			host_u.send_line(mangle("err?"), 0);
			wait_n(3);
			check({syntax_error, poll_status_byte[SB_ERROR]}, 2'b00);
		end
	endtask : run
////////////////////////////////////////
	// Bound sized well above the whole sequence so a stuck handshake ends the run
	initial begin
		#500000;
		errors++;
		stop_test();
	end
	initial begin
		do_reset(1'b1);
		check({poll_status_byte[7], poll_status_byte[3:1], service_request}, 5'h11);
		check(poll_status_byte[SB_RQS], 1'b1);
		check(power_on_flag, 1'b1);
		host_u.pulse(1'b1);
		wait_n(2);
		check({poll_status_byte[SB_RQS], parallel_poll_bit}, 2'b01);
		check(poll_status_byte[SB_READY], 1'b1);
		exec_busy = 1'b1;
		wait_n(3);
		check(poll_status_byte[SB_READY], 1'b0);
		exec_busy = 1'b0;
		wait_n(3);
		check(poll_status_byte[SB_READY], 1'b1);
		foreach (good[i]) run(mangle(good[i]), 1'b0);
		foreach (bad[i]) run(bad[i], 1'b1);
		f = $unsigned($random(seed)) % NUM_FAULTS;
		fault_in[f] = 1'b1;
		wait_n(3);
		check({service_request, fault_reg[f], poll_status_byte[SB_FAULT]}, 3'h3);
		fault_in = '0;
		source_enable = '1;
		wait_n(2);
		fault_in[f] = 1'b1;
		wait_n(3);
		check({service_request, poll_status_byte[SB_RQS]}, 2'b11);
		fault_in = '0;
		source_enable = '0;
		run(mangle("fault?"), 1'b0);
		check(poll_status_byte[SB_FAULT], 1'b0);
		host_u.pulse(1'b1);
		wait_n(2);
		check({service_request, poll_status_byte[SB_RQS]}, 2'b00);
		run(mangle("clr"), 1'b0);
		check({poll_status_byte[SB_PON], parallel_poll_bit}, 2'b00);
		check(last_kw, KW_CLR);
		do_reset(1'b0);
		check({power_on_flag, poll_status_byte[SB_PON]}, 2'b01);
		host_u.pulse(1'b0);
		wait_n(3);
		check(poll_status_byte[SB_PON], 1'b0);
		stop_test();
	end
endmodule : instrument_command_parser_status_tb_top
